// ### logic/ddbm_defines.vh
// register map, field layout and timing constants for the disk dma bus master
`ifndef DDBM_DEFINES_VH
`define DDBM_DEFINES_VH
`define DDBM_PORT_MODE_WR 10'h200
`define DDBM_PORT_MODE_RD 10'h202
`define DDBM_PORT_COUNT_RD 10'h204
`define DDBM_PORT_ADDR_RD 10'h206
`define DDBM_PORT_ADDR_HI 10'h208
`define DDBM_PORT_ADDR_LO 10'h20A
`define DDBM_PORT_COUNT_WR 10'h20C
`define DDBM_PORT_CMD_STAT 10'h210
`define DDBM_PORT_TAG 10'h212
`define DDBM_PORT_DISK 10'h214
`define DDBM_PORT_LAUNCH 10'h216
`define DDBM_MODE_RESET 3'h3
`define DDBM_FIFO_WIDTH 17
`define DDBM_FIFO_DEPTH 32
`define DDBM_FIFO_AW 5
`define DDBM_ST_IDLE 3'h0
`define DDBM_ST_T1 3'h1
`define DDBM_ST_T2 3'h2
`define DDBM_ST_T3 3'h3
`define DDBM_ST_TW 3'h4
`define DDBM_ST_T4 3'h5
`define DDBM_ST_DONE 3'h6
`endif

// ### logic/ddbm_fifo.v
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ddbm_fifo #(
    parameter WIDTH = 17,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady,
    output wire empty,
    output wire full
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_ff;
    reg [AW-1:0] rdPtr_ff;
    reg [AW:0] level_ff;
    wire doWrite;
    wire doRead;

    assign full = (level_ff == DEPTH[AW:0]);
    assign empty = (level_ff == {(AW+1){1'b0}});
    assign inReady = ~full;
    assign outValid = ~empty;
    assign outData = mem[rdPtr_ff];
    assign doWrite = inValid & ~full;
    assign doRead = outReady & ~empty;

    // storage has no reset, pointers do
    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    // pointer and fill level bookkeeping
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            level_ff <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doRead) begin
                rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doWrite && !doRead) begin
                level_ff <= level_ff + {{AW{1'b0}}, 1'b1};
            end else if (doRead && !doWrite) begin
                level_ff <= level_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/ddbm_top.v
// disk dma bus master: i/o port registers, memory cycle sequencer and data buffer
`timescale 1ns/1ps
`default_nettype none
`include "ddbm_defines.vh"
// Overview of operation
// [R1] stretch each mastered memory cycle with wait states while memory is slow
// [R2] ready low at rising edge in T2 adds a wait state, one more per clock
// [R3] ready low at start of T3 adds a wait state, one more per clock
// [R4] ready held low until 1.5 clocks before T4 still waits correctly
// [R5] registers are i/o ports; some ports differ on read and write
// [R6] only address bits 8..1 count; upper bits fixed, one 256-word page
// [R7] software always gives an even transfer address
// [R8] keep a working word count and a shadow of the programmed count
// [R9] write 0208H loads address 23..9 from data 15..1
// [R10] write 020AH loads address 8..1 from data 8..1, bit 0 ignored
// [R11] upper address write restores word counter and low address counter
// [R12] read 0206H gives current address 8..1 while not bus master
// [R13] word count is 8 bits, shifted left one, two's complement, up to 256
// [R14] write 020CH loads the word count in shifted two's complement form
// [R15] read 0204H returns current word count in the same shifted form
// [R16] port 0210H is command on write and status on read
// [R17] write 0212H presets the tag bit fed into the buffer
// [R18] port 0214H reaches disk controller control and status
// [R19] write 0200H copies data 3..1 into the counter mode field
// [R20] read 0202H returns the counter mode field on data 3..1
// [R21] software loads count and counter with two's complement of words
// [R22] command bit 0 selects direction, 1 memory to disk, reset disk to memory
// [R23] status bit 0 sets on error, sticks until reset, others freeze
// [R24] memory ready input is synchronised before the sequencer samples it
// [R25] unused ports ignore writes and read as zero
module ddbm_top (
    input wire sys_clk,
    input wire resetn,
    input wire [9:0] ioAddr,
    input wire [15:0] ioWrData,
    input wire ioWrite,
    input wire ioRead,
    output reg [15:0] ioRdData_ff,
    input wire memory_ready_in,
    input wire busGrant,
    output reg busRequest_ff,
    output reg busActive_ff,
    output reg [23:0] memAddr_ff,
    output reg memStrobe_ff,
    output reg memWriteEn_ff,
    output reg [15:0] memWrData_ff,
    input wire [15:0] memRdData,
    input wire dmaError,
    output reg [15:0] diskCtrlData_ff,
    output reg diskCtrlWrite_ff,
    input wire [15:0] diskCtrlStatus,
    input wire [16:0] diskInData,
    input wire diskInValid,
    output reg diskInReady_ff,
    output reg [16:0] diskOutData_ff,
    output reg diskOutValid_ff,
    input wire diskOutReady,
    output reg transferDone_ff
);
    reg [2:0] counter_mode_field_ff;
    reg [14:0] addrHigh_ff;
    reg [7:0] startLow_ff;
    reg [7:0] curLow_ff;
    reg [7:0] countShadow_ff;
    reg [7:0] countWork_ff;
    reg transfer_direction_bit_ff;
    reg tagPreset_ff;
    reg errorSticky_ff;
    reg running_ff;
    reg [15:0] frozenStatus_ff;
    reg readySync1_ff;
    reg readySync2_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg lastWord_ff;
    wire ioWrEn;
    wire ioRdEn;
    wire [15:0] liveStatus;
    wire memToDisk;
    // fifo wiring: fill side is memory (mem->disk) or disk port (disk->mem)
    wire [16:0] fifoInData;
    wire fifoInValid;
    wire fifoInReady;
    wire [16:0] fifoOutData;
    wire fifoOutValid;
    wire fifoOutReady;
    wire fifoEmpty;
    wire fifoFull;
    wire fifoOutOfBound;
    wire cycleStart;
    wire cycleEnd;

    assign ioWrEn = ioWrite; // see [R5]
    assign ioRdEn = ioRead;
    assign memToDisk = transfer_direction_bit_ff;
    // no buffer room or no data, depending on direction
    assign fifoOutOfBound = memToDisk ? fifoFull : fifoEmpty;

    // ready pin into the clock domain before the sequencer looks at it
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            readySync1_ff <= 1'b0;
            readySync2_ff <= 1'b0;
        end else begin
            readySync1_ff <= memory_ready_in; // see [R24]
            readySync2_ff <= readySync1_ff;
        end
    end

    // port writes; unlisted ports fall through with no effect
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            counter_mode_field_ff <= `DDBM_MODE_RESET;
            addrHigh_ff <= 15'h0000;
            startLow_ff <= 8'h00;
            countShadow_ff <= 8'h00;
            transfer_direction_bit_ff <= 1'b0; // see [R22]
            tagPreset_ff <= 1'b0;
            diskCtrlData_ff <= 16'h0000;
            diskCtrlWrite_ff <= 1'b0;
        end else begin
            diskCtrlWrite_ff <= 1'b0;
            if (ioWrEn) begin
                case (ioAddr)
                    `DDBM_PORT_MODE_WR: begin
                        counter_mode_field_ff <= ioWrData[3:1]; // see [R19]
                    end
                    `DDBM_PORT_ADDR_HI: begin
                        addrHigh_ff <= ioWrData[15:1]; // see [R9]
                    end
                    `DDBM_PORT_ADDR_LO: begin
                        startLow_ff <= ioWrData[8:1]; // see [R10]
                    end
                    `DDBM_PORT_COUNT_WR: begin
                        countShadow_ff <= ioWrData[8:1]; // see [R13] [R14]
                    end
                    `DDBM_PORT_CMD_STAT: begin
                        transfer_direction_bit_ff <= ioWrData[0]; // see [R16] [R22]
                    end
                    `DDBM_PORT_TAG: begin
                        tagPreset_ff <= ioWrData[0]; // see [R17]
                    end
                    `DDBM_PORT_DISK: begin
                        diskCtrlData_ff <= ioWrData; // see [R18]
                        diskCtrlWrite_ff <= 1'b1;
                    end
                    default: begin
                        diskCtrlWrite_ff <= 1'b0; // see [R25]
                    end
                endcase
            end
        end
    end

    // status word: error, run, end-of-transfer low, bound low, empty low, full low, tag, dir
    assign liveStatus = {8'h00, transfer_direction_bit_ff, fifoOutData[16], ~fifoFull,
                         ~fifoEmpty, ~fifoOutOfBound, ~transferDone_ff, running_ff, 1'b0};

    // error sticks; status snapshot held so other bits freeze at pre-error values
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            errorSticky_ff <= 1'b0;
            frozenStatus_ff <= 16'h0000;
        end else begin
            if (!errorSticky_ff) begin
                frozenStatus_ff <= liveStatus;
            end
            if (dmaError) begin
                errorSticky_ff <= 1'b1; // see [R23]
            end
        end
    end

    // port reads, registered; unused ports read zero
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ioRdData_ff <= 16'h0000;
        end else if (ioRdEn) begin
            case (ioAddr)
                `DDBM_PORT_MODE_RD: begin
                    ioRdData_ff <= {12'h000, counter_mode_field_ff, 1'b0}; // see [R20]
                end
                `DDBM_PORT_COUNT_RD: begin
                    ioRdData_ff <= {7'h00, countWork_ff, 1'b0}; // see [R15]
                end
                `DDBM_PORT_ADDR_RD: begin
                    // address is only stable for reading between mastered cycles
                    ioRdData_ff <= busActive_ff ? 16'h0000 : {7'h00, curLow_ff, 1'b0}; // see [R12]
                end
                `DDBM_PORT_CMD_STAT: begin
                    ioRdData_ff <= errorSticky_ff ? {frozenStatus_ff[15:1], 1'b1}
                                                  : liveStatus; // see [R16] [R23]
                end
                `DDBM_PORT_DISK: begin
                    ioRdData_ff <= diskCtrlStatus; // see [R18]
                end
                default: begin
                    ioRdData_ff <= 16'h0000; // see [R25]
                end
            endcase
        end
    end

    // a cycle can begin only if the buffer can take or give a word
    assign cycleStart = (state_ff == `DDBM_ST_IDLE) && running_ff && busGrant
                        && !fifoOutOfBound && !errorSticky_ff;
    assign cycleEnd = (state_ff == `DDBM_ST_T4);

    // sequencer: T1 address, T2 strobe, T3/Tw ready sample and stretch, T4 complete
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `DDBM_ST_IDLE: begin
                if (cycleStart) begin
                    nxt_state = `DDBM_ST_T1;
                end
            end
            `DDBM_ST_T1: begin
                nxt_state = `DDBM_ST_T2;
            end
            `DDBM_ST_T2: begin
                nxt_state = `DDBM_ST_T3;
            end
            `DDBM_ST_T3: begin
                // ready low when entering T3 forces a wait state
                nxt_state = readySync2_ff ? `DDBM_ST_T4 : `DDBM_ST_TW; // see [R1] [R2] [R3]
            end
            `DDBM_ST_TW: begin
                // each further clock low adds another; no upper bound on the stretch
                nxt_state = readySync2_ff ? `DDBM_ST_T4 : `DDBM_ST_TW; // see [R2] [R3] [R4]
            end
            `DDBM_ST_T4: begin
                nxt_state = lastWord_ff ? `DDBM_ST_DONE : `DDBM_ST_IDLE;
            end
            `DDBM_ST_DONE: begin
                nxt_state = `DDBM_ST_IDLE;
            end
            default: begin
                nxt_state = `DDBM_ST_IDLE;
            end
        endcase
    end

    // the launch port starts a run; upper address write rewinds counters
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= `DDBM_ST_IDLE;
            running_ff <= 1'b0;
            curLow_ff <= 8'h00;
            countWork_ff <= 8'h00;
            lastWord_ff <= 1'b0;
            transferDone_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (ioWrEn && ioAddr == `DDBM_PORT_ADDR_HI) begin
                curLow_ff <= startLow_ff; // see [R11]
                countWork_ff <= countShadow_ff; // see [R8] [R11]
            end else if (ioWrEn && ioAddr == `DDBM_PORT_ADDR_LO) begin
                curLow_ff <= ioWrData[8:1];
            end else if (ioWrEn && ioAddr == `DDBM_PORT_COUNT_WR) begin
                countWork_ff <= ioWrData[8:1]; // see [R21]
            end else if (cycleEnd) begin
                // low byte wraps within the page, upper bits untouched
                curLow_ff <= curLow_ff + 8'h01; // see [R6]
                countWork_ff <= countWork_ff + 8'h01;
            end
            if (state_ff == `DDBM_ST_T1) begin
                // two's complement count reaches zero after this word
                lastWord_ff <= (countWork_ff == 8'hFF);
            end
            if (ioWrEn && ioAddr == `DDBM_PORT_LAUNCH) begin
                running_ff <= 1'b1;
                transferDone_ff <= 1'b0;
            end else if (state_ff == `DDBM_ST_DONE) begin
                running_ff <= 1'b0;
                transferDone_ff <= 1'b1;
            end
        end
    end

    // bus pins other than the request follow the sequencer state
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busRequest_ff <= 1'b0;
            busActive_ff <= 1'b0;
            memAddr_ff <= 24'h000000;
            memStrobe_ff <= 1'b0;
            memWriteEn_ff <= 1'b0;
            memWrData_ff <= 16'h0000;
        end else begin
            busRequest_ff <= running_ff && !fifoOutOfBound && !errorSticky_ff;
            busActive_ff <= (nxt_state != `DDBM_ST_IDLE) && (nxt_state != `DDBM_ST_DONE);
            memStrobe_ff <= (nxt_state == `DDBM_ST_T2) || (nxt_state == `DDBM_ST_T3)
                            || (nxt_state == `DDBM_ST_TW);
            if (nxt_state == `DDBM_ST_T1) begin
                memAddr_ff <= {addrHigh_ff, curLow_ff, 1'b0}; // see [R6] [R7]
                memWriteEn_ff <= ~memToDisk;
                memWrData_ff <= fifoOutData[15:0];
            end
        end
    end

    // buffer fill side: memory word at T4 or disk word, by direction
    assign fifoInData = memToDisk ? {tagPreset_ff, memRdData} : diskInData; // see [R17]
    assign fifoInValid = memToDisk ? cycleEnd : diskInValid;
    // drain side: memory write at T4 or disk port taking words
    assign fifoOutReady = memToDisk ? (diskOutReady && !diskOutValid_ff) : cycleEnd;

    // disk-facing registered handshakes; disk reading stalls the buffer
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            diskInReady_ff <= 1'b0;
            diskOutValid_ff <= 1'b0;
            diskOutData_ff <= 17'h00000;
        end else begin
            diskInReady_ff <= ~memToDisk & fifoInReady;
            if (diskOutValid_ff && diskOutReady) begin
                diskOutValid_ff <= 1'b0;
            end else if (memToDisk && fifoOutValid && fifoOutReady) begin
                diskOutValid_ff <= 1'b1;
                diskOutData_ff <= fifoOutData;
            end
        end
    end

    ddbm_fifo #(
        .WIDTH(`DDBM_FIFO_WIDTH),
        .DEPTH(`DDBM_FIFO_DEPTH),
        .AW(`DDBM_FIFO_AW)
    ) u_fifo (
        .clk(sys_clk),
        .resetn(resetn),
        .inData(fifoInData),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .outData(fifoOutData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .empty(fifoEmpty),
        .full(fifoFull)
    );
endmodule
`default_nettype wire

// ### verification/ddbm_top_props.sv
// concurrent checks on the disk dma bus master ports
`timescale 1ns/1ps
`default_nettype none
module ddbm_top_props (
    input wire sys_clk,
    input wire resetn,
    input wire [9:0] ioAddr,
    input wire [15:0] ioWrData,
    input wire ioWrite,
    input wire ioRead,
    input wire [15:0] ioRdData_ff,
    input wire memory_ready_in,
    input wire busGrant,
    input wire busRequest_ff,
    input wire busActive_ff,
    input wire [23:0] memAddr_ff,
    input wire memStrobe_ff,
    input wire dmaError,
    input wire [15:0] diskCtrlData_ff,
    input wire diskCtrlWrite_ff,
    input wire [15:0] diskCtrlStatus
);
    reg errSeen_ff;
    // shadow of the sticky error, only reset clears it
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            errSeen_ff <= 1'b0;
        end else if (dmaError) begin
            errSeen_ff <= 1'b1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ready goes through two flops, so the decision lags the pin by two clocks
    a_wait_ready: assert property (memStrobe_ff && $past(memStrobe_ff) |=>
        memStrobe_ff == !$past(memory_ready_in, 3)) else $error("wait state mismatch");
    a_strobe_active: assert property (memStrobe_ff |-> busActive_ff)
        else $error("strobe outside bus cycle");
    a_start_grant: assert property ($rose(busActive_ff) |-> $past(busGrant))
        else $error("cycle without grant");
    a_page_step: assert property ($rose(busActive_ff) && $past(busActive_ff, 2) |->
        memAddr_ff[23:9] == $past(memAddr_ff[23:9], 2) && !memAddr_ff[0]
        && memAddr_ff[8:1] == $past(memAddr_ff[8:1], 2) + 8'h01) else $error("address step");
    a_busy_addr: assert property (ioRead && ioAddr == 10'h206 && busActive_ff |=>
        ioRdData_ff == 16'h0000) else $error("address read while master");
    a_unused_read: assert property (ioRead && ioAddr >= 10'h218 |=> ioRdData_ff == 16'h0000)
        else $error("unused port read");
    a_err_status: assert property (errSeen_ff && ioRead && ioAddr == 10'h210 |=>
        ioRdData_ff[0]) else $error("error bit not sticky");
    a_err_norequest: assert property ($past(errSeen_ff, 2) |-> !busRequest_ff)
        else $error("request after error");
    a_disk_write: assert property (ioWrite && ioAddr == 10'h214 |=>
        diskCtrlWrite_ff && diskCtrlData_ff == $past(ioWrData)) else $error("disk write");
    a_disk_read: assert property (ioRead && ioAddr == 10'h214 |=>
        ioRdData_ff == $past(diskCtrlStatus)) else $error("disk status read");
    a_read_hold: assert property (!ioRead |=> $stable(ioRdData_ff))
        else $error("read data moved");
endmodule
bind ddbm_top ddbm_top_props u_props (.sys_clk, .resetn, .ioAddr, .ioWrData, .ioWrite,
    .ioRead, .ioRdData_ff, .memory_ready_in, .busGrant, .busRequest_ff, .busActive_ff,
    .memAddr_ff, .memStrobe_ff, .dmaError, .diskCtrlData_ff, .diskCtrlWrite_ff,
    .diskCtrlStatus);
`default_nettype wire

// ### verification/ddbm_mem_model.sv
// slow memory and bus arbiter standing on the processor bus side
`timescale 1ns/1ps
`default_nettype none
module ddbm_mem_model (
    input wire sys_clk,
    input wire resetn,
    input wire busRequest_ff,
    input wire busActive_ff,
    input wire [23:0] memAddr_ff,
    input wire memStrobe_ff,
    input wire memWriteEn_ff,
    input wire [15:0] memWrData_ff,
    input wire [7:0] waitLen,
    output logic busGrant,
    output logic memory_ready_in,
    output logic [15:0] memRdData
);
    logic [7:0] lowCnt;
    logic actPrev;
    logic strbPrev;
    logic [15:0] lastRd;
    int strbCnt;
    logic [23:0] addrQ[$];
    logic [15:0] dataQ[$];
    // ready pulled low from the address phase on, giving waitLen wait states
    assign memory_ready_in = (lowCnt == 8'h00)
        && !(busActive_ff && !actPrev && waitLen != 8'h00);
    // released bus shows the inverse of the last word, never a stale copy
    assign memRdData = busActive_ff ? (memAddr_ff[15:0] ^ 16'h5A5A) : lastRd;
    // grant lags request one clock; cycles are logged as the strobe ends
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busGrant <= 1'b0;
            lowCnt <= 8'h00;
            actPrev <= 1'b0;
            strbPrev <= 1'b0;
            lastRd <= 16'h0000;
            strbCnt <= 0;
        end else begin
            if (memStrobe_ff) begin
                strbCnt <= strbCnt + 1;
            end
            busGrant <= busRequest_ff;
            actPrev <= busActive_ff;
            strbPrev <= memStrobe_ff;
            if (busActive_ff) begin
                lastRd <= ~(memAddr_ff[15:0] ^ 16'h5A5A);
            end
            if (busActive_ff && !actPrev) begin
                lowCnt <= (waitLen == 8'h00) ? 8'h00 : waitLen - 8'h01;
            end else if (lowCnt != 8'h00) begin
                lowCnt <= lowCnt - 8'h01;
            end
            if (strbPrev && !memStrobe_ff) begin
                addrQ.push_back(memAddr_ff);
                if (memWriteEn_ff) begin
                    dataQ.push_back(memWrData_ff);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/ddbm_top_tb.sv
// self-checking bench for the disk dma bus master
`timescale 1ns/1ps
`default_nettype none
`include "ddbm_defines.vh"
module ddbm_top_tb;
    logic sys_clk = 1'b0, resetn = 1'b0, ioWrite = 1'b0, ioRead = 1'b0, dmaError = 1'b0;
    logic [9:0] ioAddr = 10'h000;
    logic [15:0] ioWrData = 16'h0000, diskCtrlStatus = 16'h5AC3;
    logic [16:0] diskInData = 17'h00000;
    logic diskInValid = 1'b0, diskOutReady = 1'b1;
    logic [7:0] waitLen = 8'h00;
    logic [15:0] ioRdData_ff, memWrData_ff, memRdData, diskCtrlData_ff;
    logic [23:0] memAddr_ff;
    logic [16:0] diskOutData_ff;
    logic memory_ready_in, busGrant, busRequest_ff, busActive_ff, memStrobe_ff;
    logic memWriteEn_ff, diskCtrlWrite_ff, diskInReady_ff, diskOutValid_ff, transferDone_ff;
    logic [16:0] outQ[$];
    int errCount = 0, testsRun = 0;
    ddbm_top dut (.sys_clk, .resetn, .ioAddr, .ioWrData, .ioWrite, .ioRead, .ioRdData_ff,
        .memory_ready_in, .busGrant, .busRequest_ff, .busActive_ff, .memAddr_ff,
        .memStrobe_ff, .memWriteEn_ff, .memWrData_ff, .memRdData, .dmaError,
        .diskCtrlData_ff, .diskCtrlWrite_ff, .diskCtrlStatus, .diskInData, .diskInValid,
        .diskInReady_ff, .diskOutData_ff, .diskOutValid_ff, .diskOutReady, .transferDone_ff);
    ddbm_mem_model mem (.sys_clk, .resetn, .busRequest_ff, .busActive_ff, .memAddr_ff,
        .memStrobe_ff, .memWriteEn_ff, .memWrData_ff, .waitLen, .busGrant,
        .memory_ready_in, .memRdData);
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    // disk side stalls every other clock
    always @(negedge sys_clk) diskOutReady <= ~diskOutReady;
    // words taken by the disk side
    always @(posedge sys_clk) begin
        if (diskOutValid_ff && diskOutReady) begin
            outQ.push_back(diskOutData_ff);
        end
    end
    task automatic endSim();
        if (errCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one port access per two clocks so strobes never merge
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        ioAddr = a;
        ioWrData = d;
        ioWrite = 1'b1;
        @(negedge sys_clk);
        ioWrite = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] m, input logic [15:0] e);
        ioAddr = a;
        ioRead = 1'b1;
        @(negedge sys_clk);
        ioRead = 1'b0;
        chk({8'h00, ioRdData_ff & m}, {8'h00, e});
        @(negedge sys_clk);
    endtask
    task automatic waitDone();
        int i;
        for (i = 0; i < 3000 && transferDone_ff !== 1'b1; i++) @(negedge sys_clk);
        if (i == 3000) begin
            errCount++;
            endSim();
        end
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic rst();
        resetn = 1'b0;
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
    endtask
    initial begin
        int i;
        int n;
        rst();
        rd(`DDBM_PORT_MODE_RD, 16'h000E, 16'h0006);
        rd(`DDBM_PORT_CMD_STAT, 16'h0081, 16'h0000);
        wr(10'h21A, 16'hFFFF);
        rd(10'h218, 16'hFFFF, 16'h0000);
        wr(`DDBM_PORT_MODE_WR, 16'h000A);
        rd(`DDBM_PORT_MODE_RD, 16'h000E, 16'h000A);
        wr(`DDBM_PORT_MODE_WR, 16'hFFF7);
        rd(`DDBM_PORT_MODE_RD, 16'h000E, 16'h0006);
        wr(`DDBM_PORT_COUNT_WR, 16'h01FE);
        rd(`DDBM_PORT_COUNT_RD, 16'h01FE, 16'h01FE);
        wr(`DDBM_PORT_COUNT_WR, 16'hFE01);
        rd(`DDBM_PORT_COUNT_RD, 16'h01FE, 16'h0000);
        wr(`DDBM_PORT_ADDR_LO, 16'h01FF);
        rd(`DDBM_PORT_ADDR_RD, 16'h01FE, 16'h01FE);
        wr(`DDBM_PORT_DISK, 16'h1234);
        chk({8'h00, diskCtrlData_ff}, 24'h001234);
        rd(`DDBM_PORT_DISK, 16'hFFFF, 16'h5AC3);
        // two words memory to disk across the end of a page
        waitLen = 8'h03;
        wr(`DDBM_PORT_ADDR_LO, 16'h01FE);
        wr(`DDBM_PORT_COUNT_WR, 16'h01FD);
        wr(`DDBM_PORT_TAG, 16'h0001);
        wr(`DDBM_PORT_ADDR_HI, 16'h0247);
        wr(`DDBM_PORT_CMD_STAT, 16'h0001);
        rd(`DDBM_PORT_CMD_STAT, 16'h0080, 16'h0080);
        wr(`DDBM_PORT_LAUNCH, 16'h0000);
        waitDone();
        chk(mem.addrQ.size(), 24'h2);
        chk(mem.addrQ[0], 24'h0247FE);
        chk(mem.addrQ[1], 24'h024600);
        chk(mem.dataQ.size(), 24'h0);
        chk(mem.strbCnt[23:0], 24'h00000A);
        chk({7'h00, outQ[0]}, 24'h011DA4);
        chk({7'h00, outQ[1]}, 24'h011C5A);
        rd(`DDBM_PORT_COUNT_RD, 16'h01FE, 16'h0000);
        rd(`DDBM_PORT_ADDR_RD, 16'h01FE, 16'h0002);
        wr(`DDBM_PORT_ADDR_HI, 16'h0247);
        rd(`DDBM_PORT_COUNT_RD, 16'h01FE, 16'h01FC);
        rd(`DDBM_PORT_ADDR_RD, 16'h01FE, 16'h01FE);
        // fill the buffer from the disk side until it refuses
        wr(`DDBM_PORT_CMD_STAT, 16'h0000);
        n = 0;
        for (i = 0; i < 40; i++) begin
            diskInData = {1'b0, n[15:0]};
            diskInValid = 1'b1;
            @(posedge sys_clk);
            if (diskInReady_ff === 1'b1) n++;
            @(negedge sys_clk);
        end
        diskInValid = 1'b0;
        chk(n[23:0], 24'h000021);
        rd(`DDBM_PORT_CMD_STAT, 16'h0030, 16'h0010);
        // drain 32 words into a memory that is slow
        mem.addrQ.delete();
        waitLen = 8'h05;
        wr(`DDBM_PORT_ADDR_LO, 16'h0000);
        wr(`DDBM_PORT_COUNT_WR, 16'h01C0);
        wr(`DDBM_PORT_ADDR_HI, 16'h0000);
        wr(`DDBM_PORT_LAUNCH, 16'h0000);
        repeat (2) @(negedge sys_clk);
        rd(`DDBM_PORT_ADDR_RD, 16'h01FE, 16'h0000);
        waitDone();
        chk(mem.dataQ.size(), 24'd32);
        for (i = 0; i < 32; i++) chk({8'h00, mem.dataQ[i]}, i[23:0]);
        chk(mem.addrQ[31], 24'h00003E);
        chk(mem.strbCnt[23:0], 24'h0000EA);
        rd(`DDBM_PORT_CMD_STAT, 16'h0010, 16'h0000);
        // error sticks and blocks further cycles until reset
        dmaError = 1'b1;
        @(negedge sys_clk);
        dmaError = 1'b0;
        rd(`DDBM_PORT_CMD_STAT, 16'h0001, 16'h0001);
        wr(`DDBM_PORT_LAUNCH, 16'h0000);
        repeat (20) @(negedge sys_clk);
        chk({23'h0, busActive_ff}, 24'h0);
        rst();
        rd(`DDBM_PORT_CMD_STAT, 16'h0081, 16'h0000);
        rd(`DDBM_PORT_MODE_RD, 16'h000E, 16'h0006);
        endSim();
    end
endmodule
`default_nettype wire
